//--- rtl/pin_filter.sv
/*
  Three-stage synchroniser for one pin; the clean level follows once the
  second and third stages agree.
  Assumes an asynchronous input and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module pin_filter (
  input wire logic mclk,
  input wire logic sys_rst,
  pin_sync_if.filt pin
);
  logic meta1_reg;
  logic meta2_reg;
  logic meta3_reg;
  logic clean_reg;

  // ------------------------------------------------------------
  // synchroniser and agreement filter
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta1_reg <= 1'b0;
      meta2_reg <= 1'b0;
      meta3_reg <= 1'b0;
      clean_reg <= 1'b0;
    end else begin
      meta1_reg <= pin.raw;
      meta2_reg <= meta1_reg;
      meta3_reg <= meta2_reg;
      if (meta2_reg == meta3_reg) begin
        clean_reg <= meta3_reg;
      end
    end
  end

  assign pin.clean = clean_reg;
endmodule

//--- rtl/pin_sync_if.sv
/*
  Interface carrying an asynchronous pin level and its filtered copy.
  Assumes both ends run on the same clock as the filter.
*/
`timescale 1ns/10ps
interface pin_sync_if;
  logic raw;
  logic clean;

  modport filt (
    input  raw,
    output clean
  );
  modport user (
    output raw,
    input  clean
  );
endinterface

//--- rtl/sar_adc_control.sv
/*
  Digital control of a ten-bit successive-approximation converter with an
  APB register slave, conversion clock divider and approximation engine.
  Assumes an analog front end that multiplexes the selected input, tracks
  it while sampleHold is high and holds it while low, and reports on compHigh whether the held
  input lies above dacCode.
*/
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
`include "sar_adc_defs.svh"
module sar_adc_control
  import sar_adc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [`ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              haltMode,
  input  wire logic              compHigh,
  output logic      [3:0]        inputSelector,
  output logic                   channelValid,
  output logic                   converterPowerOn,
  output logic                   sampleHold,
  output logic      [`RESULT_BITS-1:0] dacCode
);

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  function automatic logic [`ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction

  function automatic result_t bit_mask(input logic [3:0] idx);
    bit_mask = result_t'(1) << idx;
  endfunction

  function automatic logic chan_defined(input channel_t ch);
    chan_defined = !((ch == 4'h6) || (ch == 4'h7) ||
                     (ch == 4'h9) || (ch == 4'hB));
  endfunction

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic        speed_reg;
  logic        converter_power_on_reg;
  channel_t    chan_reg;
  logic        eoc_reg;
  logic        eoc_next;
  result_t     result_reg;
  conv_state_e state_reg;
  conv_state_e state_next;
  logic [3:0]  phase_reg;
  logic [3:0]  phase_next;
  logic [3:0]  bitIdx_reg;
  logic [3:0]  bitIdx_next;
  result_t     approx_reg;
  result_t     approx_next;
  result_t     dac_reg;
  logic [1:0]  div_reg;
  logic [1:0]  div_next;
  logic [31:0] rdata_reg;
  logic        err_reg;
  logic        convDone;

  wire logic       setupPhase;
  wire logic       accessPhase;
  wire logic       hitCsr;
  wire logic       hitHigh;
  wire logic       hitLow;
  wire logic       mapped;
  wire logic       ctrlWrite;
  wire logic       highRead;
  wire logic       restart;
  wire logic       run;
  wire logic [1:0] divLimit;
  wire logic       tick;
  wire logic       compClean;
  wire result_t    trial;
  wire logic [7:0] csrView;
  wire logic [7:0] highView;
  wire logic [7:0] lowView;
  wire logic [7:0] readMux;

  // ------------------------------------------------------------
  // comparator synchroniser
  // ------------------------------------------------------------
  pin_sync_if compSync ();

  assign compSync.raw = compHigh;
  assign compClean    = compSync.clean;

  pin_filter compFilter (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .pin     (compSync)
  );

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  assign hitCsr      = (paddr == reg_addr(`CSR_INDEX));
  assign hitHigh     = (paddr == reg_addr(`RES_HIGH_INDEX));
  assign hitLow      = (paddr == reg_addr(`RES_LOW_INDEX));
  assign mapped      = hitCsr | hitHigh | hitLow;
  assign ctrlWrite   = accessPhase & pwrite & hitCsr;
  assign highRead    = accessPhase & ~pwrite & hitHigh;

  // no wait states: every access phase completes at once
  assign pready  = 1'b1;
  assign pslverr = accessPhase & err_reg;
  assign prdata  = rdata_reg;

  // ------------------------------------------------------------
  // register views
  // ------------------------------------------------------------
  // bit four always reads zero, software writes to it are dropped
  assign csrView  = {eoc_reg, speed_reg, converter_power_on_reg, 1'b0, chan_reg};
  assign highView = result_reg[`RESULT_BITS-1:2];
  assign lowView  = {6'h00, result_reg[1:0]};
  assign readMux  = hitCsr  ? csrView  :
                    hitHigh ? highView :
                    hitLow  ? lowView  : 8'h00;

  // read data is captured in the setup phase and held through access
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_reg <= 32'h00000000;
      err_reg   <= 1'b0;
    end else if (setupPhase) begin
      rdata_reg <= {24'h000000, readMux};
      err_reg   <= ~mapped;
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  // end flag field of the written word is ignored
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      speed_reg <= 1'b0;
      converter_power_on_reg  <= 1'b0;
      chan_reg  <= 4'h0;
    end else if (ctrlWrite) begin
      speed_reg <= pwdata[`CSR_SPEED_BIT];
      converter_power_on_reg  <= pwdata[`CSR_ON_BIT];
      chan_reg  <= pwdata[`CSR_CH_MSB:0];
    end
  end

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  // besides the power-on bit only halt gates the converter; wait mode is not an input at all
  assign run     = converter_power_on_reg & ~haltMode;
  // any control write, including a channel change, restarts
  assign restart = ctrlWrite;

  assign inputSelector    = chan_reg;
  assign channelValid     = chan_defined(chan_reg);
  assign converterPowerOn = run;

  // ------------------------------------------------------------
  // conversion clock divider
  // ------------------------------------------------------------
  assign divLimit = speed_reg ? `DIV2_LIMIT : `DIV4_LIMIT;
  assign tick     = run & (div_reg == divLimit);

  always_comb begin
    if (!run || restart || tick) begin
      div_next = 2'h0;
    end else begin
      div_next = div_reg + 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_next;
    end
  end

  // ------------------------------------------------------------
  // approximation engine
  // ------------------------------------------------------------
  assign trial = approx_reg | bit_mask(bitIdx_reg);

  always_comb begin
    state_next  = state_reg;
    phase_next  = phase_reg;
    bitIdx_next = bitIdx_reg;
    approx_next = approx_reg;
    convDone    = 1'b0;
    if (!run) begin
      state_next  = ST_IDLE;
      phase_next  = 4'h0;
      approx_next = `RESULT_RESET;
    end else if (restart) begin
      state_next  = ST_SAMPLE;
      phase_next  = 4'h0;
      approx_next = `RESULT_RESET;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          state_next  = ST_SAMPLE;
          phase_next  = 4'h0;
          approx_next = `RESULT_RESET;
        end
        ST_SAMPLE: begin
          if (tick) begin
            if (phase_reg == `SAMPLE_TICKS - 4'h1) begin
              state_next  = ST_STEP;
              phase_next  = 4'h0;
              bitIdx_next = 4'(`RESULT_BITS - 1);
            end else begin
              phase_next = phase_reg + 4'h1;
            end
          end
        end
        ST_STEP: begin
          if (tick) begin
            if (phase_reg == `STEP_TICKS - 4'h1) begin
              phase_next = 4'h0;
              // a bit is kept while the input stays above the trial,
              // so out-of-range inputs end at all ones or all zeros
              approx_next = compClean ? trial : approx_reg;
              if (bitIdx_reg == 4'h0) begin
                state_next = ST_DONE;
              end else begin
                bitIdx_next = bitIdx_reg - 4'h1;
              end
            end else begin
              phase_next = phase_reg + 4'h1;
            end
          end
        end
        ST_DONE: begin
          convDone    = 1'b1;
          state_next  = ST_SAMPLE;
          phase_next  = 4'h0;
          approx_next = `RESULT_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg  <= ST_IDLE;
      phase_reg  <= 4'h0;
      bitIdx_reg <= 4'h0;
      approx_reg <= `RESULT_RESET;
    end else begin
      state_reg  <= state_next;
      phase_reg  <= phase_next;
      bitIdx_reg <= bitIdx_next;
      approx_reg <= approx_next;
    end
  end

  // ------------------------------------------------------------
  // trial code to the analog side
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dac_reg <= `RESULT_RESET;
    end else if (state_next == ST_STEP) begin
      dac_reg <= approx_next | bit_mask(bitIdx_next);
    end else begin
      dac_reg <= `RESULT_RESET;
    end
  end

  assign dacCode    = dac_reg;
  assign sampleHold = (state_reg == ST_SAMPLE);

  // ------------------------------------------------------------
  // result and end flag
  // ------------------------------------------------------------
  // result is replaced at every completion, nothing waits for a read
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      result_reg <= `RESULT_RESET;
    end else if (convDone) begin
      result_reg <= approx_reg;
    end
  end

  // completion wins over a clear in the same cycle; no interrupt exists
  assign eoc_next = convDone |
                    (eoc_reg & ~(ctrlWrite | highRead));

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      eoc_reg <= 1'b0;
    end else begin
      eoc_reg <= eoc_next;
    end
  end

endmodule

//--- rtl/sar_adc_defs.svh
/*
  Constants of the converter control block: register indices, field
  positions, reset values and conversion timing counts.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH

// Operation
// - high result byte holds result bits nine..two
// - low byte holds bits one..zero, rest zero
// - over upper reference saturates to all ones
// - below lower reference gives all zeros
// - power-on bit starts continuous conversion
// - clearing power-on stops conversion, powers down
// - hardware sets end flag, software cannot
// - high byte read or control write clears flag
// - control write restarts conversion from beginning
// - channel change restarts, clears flag
// - results overwritten each conversion, not held
// - clock select: zero divides four, one two
// - channel code N selects input N
// - wait mode no effect, halt disables converter
// - all registers read zero after reset

// ------------------------------------------------------------
// register indices, byte address is four times the index
// ------------------------------------------------------------
`define ADDR_W          12
`define CSR_INDEX       8'h70
`define RES_HIGH_INDEX  8'h71
`define RES_LOW_INDEX   8'h72

// ------------------------------------------------------------
// control and status fields
// ------------------------------------------------------------
`define CSR_EOC_BIT     7
`define CSR_SPEED_BIT   6
`define CSR_ON_BIT      5
`define CSR_CH_MSB      3
`define CSR_RESET       8'h00
`define RESULT_RESET    10'h000

// ------------------------------------------------------------
// conversion timing in converter clock ticks
// ------------------------------------------------------------
`define RESULT_BITS     10
`define SAMPLE_TICKS    4'h4
`define STEP_TICKS      4'h3
`define DIV4_LIMIT      2'h3
`define DIV2_LIMIT      2'h1

`endif

//--- rtl/sar_adc_pkg.sv
/*
  Types of the converter control block.
  Assumes the constants header is on the include path.
*/
package sar_adc_pkg;
  `include "sar_adc_defs.svh"

  typedef logic [`RESULT_BITS-1:0] result_t;
  typedef logic [3:0]              channel_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_STEP   = 4'b0100,
    ST_DONE   = 4'b1000
  } conv_state_e;
endpackage

//--- testbench/analog_front_model.sv
/*
  Analog front end: channel mux, sample-hold and comparator.
  Assumes the held input is level xor channel code, half an LSB above.
*/
`timescale 1ns/10ps
module analog_front_model (
  input wire logic       mclk,
  input wire logic       sampleHold,
  input wire logic       converterPowerOn,
  input wire logic       channelValid,
  input wire logic [3:0] inputSelector,
  input wire logic [9:0] dacCode,
  input wire logic [9:0] level,
  output logic           compHigh
);
  logic [9:0] held = 10'h000;
  logic       toggle = 1'b0;
  always @(posedge mclk) begin
    toggle <= ~toggle;
    if (sampleHold)
      held <= level ^ {6'h00, inputSelector};
  end
  // undefined input or powered down gives a restless comparator
  assign compHigh = (converterPowerOn && channelValid) ?
                    (held >= dacCode) : toggle;
endmodule

//--- testbench/sar_adc_control_asserts.sv
/*
  Port-level checks of the converter control block.
  Assumes one clock domain and binding into sar_adc_control.
*/
`timescale 1ns/10ps
`include "sar_adc_defs.svh"
module sar_adc_control_checker
  import sar_adc_pkg::*;
(
  input wire logic                    mclk,
  input wire logic                    sys_rst,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [`ADDR_W-1:0]      paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    haltMode,
  input wire logic                    compHigh,
  input wire logic [3:0]              inputSelector,
  input wire logic                    channelValid,
  input wire logic                    converterPowerOn,
  input wire logic                    sampleHold,
  input wire logic [`RESULT_BITS-1:0] dacCode
);
  logic [7:0]              lowCnt;
  logic [7:0]              stepCnt;
  logic [`RESULT_BITS-1:0] prevCode;
  logic                    csrWrite;
  logic                    lowRead;
  assign csrWrite = psel && penable && pwrite && paddr == 12'h1C0;
  assign lowRead  = psel && penable && !pwrite && paddr == 12'h1C8;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst || sampleHold || !converterPowerOn)
      lowCnt <= 8'h00;
    else if (lowCnt != 8'hFF)
      lowCnt <= lowCnt + 8'h01;
  end
  always_ff @(posedge mclk) begin
    prevCode <= dacCode;
    if (sys_rst || dacCode != prevCode)
      stepCnt <= 8'h01;
    else if (stepCnt != 8'hFF)
      stepCnt <= stepCnt + 8'h01;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_low_zero; lowRead |-> prdata[31:2] == 30'h0; endproperty
  a_low_zero: assert property (p_low_zero)
    else $error("low byte upper bits set");
  property p_off; !converterPowerOn [*3] |-> !sampleHold && !dacCode;
  endproperty
  a_off: assert property (p_off)
    else $error("converter active while off");
  property p_halt; haltMode |-> !converterPowerOn; endproperty
  a_halt: assert property (p_halt)
    else $error("converter on during halt");
  property p_rst; $fell(sys_rst) |-> !converterPowerOn && !inputSelector
    && prdata == 32'h0 && !sampleHold; endproperty
  a_rst: assert property (p_rst)
    else $error("nonzero state after reset");
  property p_restart; csrWrite && pwdata[5] && !haltMode
    |-> ##[2:3] (sampleHold && dacCode == 10'h000); endproperty
  a_restart: assert property (p_restart)
    else $error("control write did not restart");
  property p_chan; $changed(inputSelector) && converterPowerOn
    |-> ##[1:2] sampleHold; endproperty
  a_chan: assert property (p_chan)
    else $error("channel change did not restart");
  property p_valid;
    channelValid == !(inputSelector inside {4'h6, 4'h7, 4'h9, 4'hB});
  endproperty
  a_valid: assert property (p_valid)
    else $error("channel valid decode wrong");
  property p_step; $changed(dacCode) && $past(dacCode) != 10'h000
    && dacCode != 10'h000 |-> stepCnt inside {8'h06, 8'h0C}; endproperty
  a_step: assert property (p_step)
    else $error("step length wrong");
  property p_cont; lowCnt < 8'h8C; endproperty
  a_cont: assert property (p_cont)
    else $error("conversion did not repeat");
endmodule

bind sar_adc_control sar_adc_control_checker u_sar_adc_control_checker (
  .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .haltMode(haltMode),
  .compHigh(compHigh), .inputSelector(inputSelector),
  .channelValid(channelValid), .converterPowerOn(converterPowerOn),
  .sampleHold(sampleHold), .dacCode(dacCode));

//--- testbench/sar_adc_control_test.sv
/*
  Self-checking bench of the converter control block over APB.
  Assumes the analog front model and the bound checker.
*/
`timescale 1ns/10ps
`include "sar_adc_defs.svh"
module sar_adc_control_test
  import sar_adc_pkg::*;
;
  localparam logic [11:0] CSR_A = 12'h1C0;
  localparam logic [11:0] HI_A  = 12'h1C4;
  localparam logic [11:0] LO_A  = 12'h1C8;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        haltMode = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [9:0]  level = 10'h000;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, compHigh, channelValid;
  logic        converterPowerOn, sampleHold, rerr;
  logic [3:0]  inputSelector;
  logic [9:0]  dacCode;
  int          mismatches = 0;
  int          cmpCount = 0;
  logic [7:0]  cfgT [6] = '{8'h20, 8'h60, 8'h25, 8'h6C, 8'h2F, 8'h6A};
  logic [9:0]  lvlT [6] = '{10'h3FF, 10'h000, 10'h2A5, 10'h15A,
                           10'h301, 10'h0C3};

  sar_adc_control u_sar_adc_control (.mclk(mclk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .haltMode(haltMode), .compHigh(compHigh),
    .inputSelector(inputSelector), .channelValid(channelValid),
    .converterPowerOn(converterPowerOn), .sampleHold(sampleHold),
    .dacCode(dacCode));
  analog_front_model u_analog_front_model (.mclk(mclk),
    .sampleHold(sampleHold), .converterPowerOn(converterPowerOn),
    .channelValid(channelValid), .inputSelector(inputSelector),
    .dacCode(dacCode), .level(level), .compHigh(compHigh));

  initial forever #20 mclk = ~mclk;
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check(input logic [31:0] got, exp, input string m);
    cmpCount++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(a, 1'b1, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, string m);
    logic [31:0] r;
    logic        e;
    xfer(a, 1'b0, 32'h0, r, e);
    check(r, x, m);
  endtask
  task automatic wait_eoc();
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    r = 32'h0;
    while (r[7] !== 1'b1 && n < 200) begin
      xfer(CSR_A, 1'b0, 32'h0, r, e);
      n++;
    end
    check({31'h0, r[7]}, 32'h1, "end flag");
  endtask
  task automatic conv(input logic [7:0] cfg, input logic [9:0] lvl);
    logic [9:0] x;
    x = lvl ^ {6'h00, cfg[3:0]};
    level <= lvl;
    wr(CSR_A, {24'h0, cfg | 8'h80});
    rd(CSR_A, {24'h0, cfg}, "control after write");
    wait_eoc();
    rd(LO_A, {30'h0, x[1:0]}, "low byte");
    rd(HI_A, {24'h0, x[9:2]}, "high byte");
    rd(CSR_A, {24'h0, cfg}, "flag after high read");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(CSR_A, 32'h0, "control reset");
    rd(HI_A, 32'h0, "high reset");
    rd(LO_A, 32'h0, "low reset");
    wr(HI_A, 32'hFF);
    rd(HI_A, 32'h0, "high is read only");
    xfer(12'h1CC, 1'b0, 32'h0, rdat, rerr);
    check({31'h0, rerr}, 32'h1, "unmapped error");
    $display("test reset done");
    for (int i = 0; i < 6; i++)
      conv(cfgT[i], lvlT[i]);
    $display("test conversions done");
    wait_eoc();
    level <= 10'h1E7;
    rd(HI_A, {24'h0, 8'h32}, "eight bit read");
    wait_eoc();
    rd(LO_A, 32'h1, "overwritten low");
    rd(HI_A, {24'h0, 8'h7B}, "overwritten high");
    $display("test continuous done");
    wr(CSR_A, 32'h25);
    repeat (60) @(posedge mclk);
    conv(8'h23, 10'h2C4);
    wait_eoc();
    conv(8'h23, 10'h0F0);
    $display("test restart done");
    wr(CSR_A, 32'h09);
    repeat (300) @(posedge mclk);
    rd(CSR_A, 32'h09, "no flag while off");
    haltMode <= 1'b1;
    wr(CSR_A, 32'h20);
    repeat (300) @(posedge mclk);
    rd(CSR_A, 32'h20, "no flag in halt");
    haltMode <= 1'b0;
    wait_eoc();
    $display("test power done");
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
